// *** core/ssirq_defines.svh ***
`ifndef SSIRQ_DEFINES_SVH
`define SSIRQ_DEFINES_SVH
`define SSIRQ_OFF_RX_SYNC      12'h000
`define SSIRQ_OFF_TX_SYNC      12'h004
`define SSIRQ_OFF_STATUS       12'h008
`define SSIRQ_OFF_IRQ_ENABLE   12'h00C
`define SSIRQ_OFF_IRQ_DISABLE  12'h010
`define SSIRQ_OFF_IRQ_MASK     12'h014
`define SSIRQ_OFF_CTRL         12'h018
`define SSIRQ_BIT_TX_READY     0
`define SSIRQ_BIT_TX_DRAINED   1
`define SSIRQ_BIT_END_TX_DMA   2
`define SSIRQ_BIT_TX_BUF_EMPTY 3
`define SSIRQ_BIT_RX_READY     4
`define SSIRQ_BIT_RX_OVERRUN   5
`define SSIRQ_BIT_END_RX_DMA   6
`define SSIRQ_BIT_RX_BUF_FULL  7
`define SSIRQ_BIT_TX_SYNC      10
`define SSIRQ_BIT_RX_SYNC      11
`define SSIRQ_BIT_TX_EN        16
`define SSIRQ_BIT_RX_EN        17
`define SSIRQ_IRQ_MASK_BITS    32'h00000CFF
`define SSIRQ_SYNC_WIDTH       16
`define SSIRQ_EDGE_RISING      1'h0
`define SSIRQ_EDGE_FALLING     1'h1
`endif

// *** core/ssirq_pkg.sv ***
package ssirq_pkg;
  // Events reported by the surrounding serial engine, one clock pulse or level each.
  typedef struct packed {
    logic tx_hold_empty;   // Level: transmit holding register empty.
    logic tx_shift_idle;   // Level: shifter idle, nothing pending.
    logic tx_dma_zero;     // Level: transmit dma counter is zero.
    logic tx_next_zero;    // Level: transmit next counter is zero.
    logic rx_dma_zero;     // Level: receive dma counter is zero.
    logic rx_next_zero;    // Level: receive next counter is zero.
    logic tx_cnt_write;    // Pulse: software wrote a transmit counter.
    logic rx_cnt_write;    // Pulse: software wrote a receive counter.
    logic rx_load;         // Pulse: receive holding register loaded.
    logic rx_hold_read;    // Pulse: receive holding register read.
    logic rx_sync_pulse;   // Pulse: receive frame-sync event.
  } ssirq_event_type;
  typedef enum logic [1:0] {
    SSIRQ_IDLE,
    SSIRQ_WRITE
  } ssirq_phase_type;
endpackage

// *** core/ssirq_regs.sv ***
// Design decisions made here: register access over AHB-Lite and the register offsets.
`include "ssirq_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module ssirq_regs (
  input  wire logic                      mclk,            // System clock, 50 MHz.
  input  wire logic                      rstn,            // Asynchronous reset, active low.
  input  wire logic                      hsel,            // AHB slave select.
  input  wire logic [11:0]               haddr,           // AHB byte address.
  input  wire logic [1:0]                htrans,          // AHB transfer type.
  input  wire logic                      hwrite,          // AHB write flag.
  input  wire logic [2:0]                hsize,           // AHB transfer size.
  input  wire logic [31:0]               hwdata,          // AHB write data.
  input  wire logic                      hready,          // AHB bus ready.
  output logic      [31:0]               hrdata,          // AHB read data.
  output logic                           hreadyout,       // AHB slave ready.
  output logic                           hresp,           // AHB response, always OKAY.
  input  wire ssirq_pkg::ssirq_event_type ev,             // Engine events, same clock.
  input  wire logic [15:0]               rx_sync_capture, // Captured receive sync bits.
  input  wire logic                      rx_sync_valid,   // Pulse: capture word valid.
  input  wire logic                      tx_frame_sync,   // Transmit frame-sync pin.
  output logic      [15:0]               tx_sync_bits,    // Transmit sync data to shifter.
  output logic                           transmitter_enabled, // Transmit enable control.
  output logic                           receiver_enabled,    // Receive enable control.
  output logic                           irq              // Level interrupt, active high.
);
  logic [31:0] addr_reg;
  logic        wr_reg;
  logic        rd_reg;
  logic [15:0] rx_sync_reg;
  logic [15:0] tx_sync_reg;
  logic [31:0] mask_reg;
  logic [2:0]  ctrl_reg;
  logic        end_tx_reg;
  logic        end_rx_reg;
  logic        overrun_reg;
  logic        rx_full_reg;
  logic        tx_syn_reg;
  logic        rx_syn_reg;
  logic        fs_meta_reg;
  logic        fs_sync_reg;
  logic        fs_prev_reg;
  logic        tx_edge;
  logic        status_read;
  logic [31:0] status;
  logic        tx_zero_prev_reg;
  logic        rx_zero_prev_reg;

  // Returns true when the latched address phase targets the given offset.
  function automatic logic hit(input logic [31:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  // Address phase capture; single transfers only so no wait states are needed.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      addr_reg <= 32'h00000000;
      wr_reg   <= 1'b0;
      rd_reg   <= 1'b0;
    end else if (hready) begin
      addr_reg <= {20'h00000, haddr};
      wr_reg   <= hsel && htrans[1] && hwrite;
      rd_reg   <= hsel && htrans[1] && !hwrite;
    end
  end

  // The slave never stretches a transfer and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign status_read = rd_reg && hit(addr_reg, `SSIRQ_OFF_STATUS);

  // Frame-sync pin passes two flops before edge detection.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fs_meta_reg <= 1'b0;
      fs_sync_reg <= 1'b0;
      fs_prev_reg <= 1'b0;
    end else begin
      fs_meta_reg <= tx_frame_sync;
      fs_sync_reg <= fs_meta_reg;
      fs_prev_reg <= fs_sync_reg;
    end
  end
  assign tx_edge = (ctrl_reg[2] == `SSIRQ_EDGE_RISING) ? (fs_sync_reg && !fs_prev_reg) :
                   (!fs_sync_reg && fs_prev_reg);

  // Sync holding registers; receive side loads from capture, software may also write it.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_sync_reg <= 16'h0000;
      tx_sync_reg <= 16'h0000;
    end else begin
      if (rx_sync_valid) begin
        rx_sync_reg <= rx_sync_capture;
      end else if (wr_reg && hit(addr_reg, `SSIRQ_OFF_RX_SYNC)) begin
        rx_sync_reg <= hwdata[15:0];
      end
      if (wr_reg && hit(addr_reg, `SSIRQ_OFF_TX_SYNC)) begin
        tx_sync_reg <= hwdata[15:0];
      end
    end
  end
  assign tx_sync_bits = tx_sync_reg;

  // Control: bit 0 transmit enable, bit 1 receive enable, bit 2 sync edge select.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= 3'h0;
    end else if (wr_reg && hit(addr_reg, `SSIRQ_OFF_CTRL)) begin
      ctrl_reg <= hwdata[2:0];
    end
  end
  assign transmitter_enabled = ctrl_reg[0];
  assign receiver_enabled    = ctrl_reg[1];

  // Interrupt mask; set and clear writes never overlap as they sit at different offsets.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mask_reg <= 32'h00000000;
    end else if (wr_reg && hit(addr_reg, `SSIRQ_OFF_IRQ_ENABLE)) begin
      mask_reg <= mask_reg | (hwdata & `SSIRQ_IRQ_MASK_BITS);
    end else if (wr_reg && hit(addr_reg, `SSIRQ_OFF_IRQ_DISABLE)) begin
      mask_reg <= mask_reg & ~hwdata;
    end
  end

  // Dma end flags latch on the counter's arrival at zero; a counter write clears them.
  // A zero reached in the same cycle as the write wins, so no event is lost.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      end_tx_reg       <= 1'b0;
      end_rx_reg       <= 1'b0;
      tx_zero_prev_reg <= 1'b1;
      rx_zero_prev_reg <= 1'b1;
    end else begin
      tx_zero_prev_reg <= ev.tx_dma_zero;
      rx_zero_prev_reg <= ev.rx_dma_zero;
      if (ev.tx_dma_zero && !tx_zero_prev_reg) begin
        end_tx_reg <= 1'b1;
      end else if (ev.tx_cnt_write) begin
        end_tx_reg <= 1'b0;
      end
      if (ev.rx_dma_zero && !rx_zero_prev_reg) begin
        end_rx_reg <= 1'b1;
      end else if (ev.rx_cnt_write) begin
        end_rx_reg <= 1'b0;
      end
    end
  end

  // Receive holding occupancy and overrun; a new load beats a concurrent read.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_full_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      if (ev.rx_load) begin
        rx_full_reg <= 1'b1;
      end else if (ev.rx_hold_read) begin
        rx_full_reg <= 1'b0;
      end
      if (ev.rx_load && rx_full_reg && !ev.rx_hold_read) begin
        overrun_reg <= 1'b1;
      end else if (status_read) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  // Sync seen flags stick until the status word is read; a new event wins over the read.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_syn_reg <= 1'b0;
      rx_syn_reg <= 1'b0;
    end else begin
      if (tx_edge) begin
        tx_syn_reg <= 1'b1;
      end else if (status_read) begin
        tx_syn_reg <= 1'b0;
      end
      if (ev.rx_sync_pulse) begin
        rx_syn_reg <= 1'b1;
      end else if (status_read) begin
        rx_syn_reg <= 1'b0;
      end
    end
  end

  // Status word assembly.
  always_comb begin
    status = 32'h00000000;
    status[`SSIRQ_BIT_TX_READY]     = ev.tx_hold_empty;
    status[`SSIRQ_BIT_TX_DRAINED]   = ev.tx_hold_empty && ev.tx_shift_idle;
    status[`SSIRQ_BIT_END_TX_DMA]   = end_tx_reg;
    status[`SSIRQ_BIT_TX_BUF_EMPTY] = ev.tx_dma_zero && ev.tx_next_zero;
    status[`SSIRQ_BIT_RX_READY]     = rx_full_reg;
    status[`SSIRQ_BIT_RX_OVERRUN]   = overrun_reg;
    status[`SSIRQ_BIT_END_RX_DMA]   = end_rx_reg;
    status[`SSIRQ_BIT_RX_BUF_FULL]  = ev.rx_dma_zero && ev.rx_next_zero;
    status[`SSIRQ_BIT_TX_SYNC]      = tx_syn_reg;
    status[`SSIRQ_BIT_RX_SYNC]      = rx_syn_reg;
    status[`SSIRQ_BIT_TX_EN]        = ctrl_reg[0];
    status[`SSIRQ_BIT_RX_EN]        = ctrl_reg[1];
  end

  // Read mux; write-only and unmapped offsets read as zero.
  always_comb begin
    hrdata = 32'h00000000;
    if (rd_reg) begin
      if (hit(addr_reg, `SSIRQ_OFF_RX_SYNC)) begin
        hrdata = {16'h0000, rx_sync_reg};
      end else if (hit(addr_reg, `SSIRQ_OFF_TX_SYNC)) begin
        hrdata = {16'h0000, tx_sync_reg};
      end else if (hit(addr_reg, `SSIRQ_OFF_STATUS)) begin
        hrdata = status;
      end else if (hit(addr_reg, `SSIRQ_OFF_IRQ_MASK)) begin
        hrdata = mask_reg;
      end else if (hit(addr_reg, `SSIRQ_OFF_CTRL)) begin
        hrdata = {29'h00000000, ctrl_reg};
      end
    end
  end

  // Interrupt level from enabled status bits.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask_reg);
    end
  end
endmodule
`default_nettype wire

// *** verif/ssirq_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ssirq_defines.svh"
module ssirq_properties (
  input wire logic                       mclk,                // Clock.
  input wire logic                       rstn,                // Reset.
  input wire logic                       hsel,                // Select.
  input wire logic [11:0]                haddr,               // Address.
  input wire logic [1:0]                 htrans,              // Type.
  input wire logic                       hwrite,              // Write.
  input wire logic [31:0]                hwdata,              // Wdata.
  input wire logic                       hready,              // Ready.
  input wire logic [31:0]                hrdata,              // Rdata.
  input wire ssirq_pkg::ssirq_event_type ev,                  // Events.
  input wire logic [15:0]                tx_sync_bits,        // Sync out.
  input wire logic                       transmitter_enabled, // Tx on.
  input wire logic                       receiver_enabled     // Rx on.
);
  logic st_rd_reg;
  // Marks the data phase of a status read, when hrdata carries the status word.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_rd_reg <= 1'b0;
    end else begin
      st_rd_reg <= hsel && htrans[1] && hready && !hwrite && haddr == `SSIRQ_OFF_STATUS;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // A sync word write is its address phase followed by its data phase.
  sequence tx_sync_wr;
    hsel && htrans[1] && hready && hwrite && haddr == `SSIRQ_OFF_TX_SYNC ##1 1'b1;
  endsequence
  // Two status reads with no new receive event between them.
  sequence quiet_gap;
    st_rd_reg && !ev.rx_load && !ev.rx_sync_pulse ##1 !ev.rx_load && !ev.rx_sync_pulse ##1 st_rd_reg;
  endsequence
  // A level held for a cycle must show in its status bit, whether the bit is registered or not.
  property level_bit(int b, logic v);
    st_rd_reg && $stable(v) |-> hrdata[b] == v;
  endproperty
  tx_ready_a: assert property (level_bit(0, ev.tx_hold_empty)) else $error("bit 0 wrong");
  tx_drained_a: assert property (level_bit(1, ev.tx_hold_empty && ev.tx_shift_idle)) else $error("bit 1 wrong");
  tx_buf_empty_a: assert property (level_bit(3, ev.tx_dma_zero && ev.tx_next_zero)) else $error("bit 3 wrong");
  rx_buf_full_a: assert property (level_bit(7, ev.rx_dma_zero && ev.rx_next_zero)) else $error("bit 7 wrong");
  enable_bits_a: assert property (st_rd_reg |-> hrdata[17:16] == {receiver_enabled, transmitter_enabled})
    else $error("enable bits wrong");
  tx_sync_hold_a: assert property (tx_sync_wr |=> {16'h0000, tx_sync_bits} == ($past(hwdata) & 32'h0000FFFF))
    else $error("sync bits not taken");
  read_clears_a: assert property (quiet_gap |-> hrdata[5] == 1'b0 && hrdata[11] == 1'b0)
    else $error("flags not cleared by read");
  end_rx_set_a: assert property ($past(rstn) && ev.rx_dma_zero && !$past(ev.rx_dma_zero) ##1 st_rd_reg |-> hrdata[6])
    else $error("end of receive not set");
endmodule
bind ssirq_regs ssirq_properties chk_u (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .ev(ev), .tx_sync_bits(tx_sync_bits),
  .transmitter_enabled(transmitter_enabled), .receiver_enabled(receiver_enabled));
`default_nettype wire

// *** verif/ssirq_regs_test.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ssirq_defines.svh"
`define SSIRQ_CHECK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin failures++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module ssirq_regs_test;
  logic                       mclk, rstn, hsel, hwrite, rx_sync_valid, tx_frame_sync;
  logic [1:0]                 htrans;
  logic [11:0]                haddr;
  logic [15:0]                rx_sync_capture;
  logic [31:0]                hwdata, rd;
  wire logic [31:0]           hrdata;
  wire logic [15:0]           tx_sync_bits;
  wire logic                  hreadyout, hresp, transmitter_enabled, receiver_enabled, irq;
  ssirq_pkg::ssirq_event_type ev;
  int                         failures, num_checks;
  // Rows: six counter and shifter levels, then the status bits 7, 3, 1 and 0 they give.
  logic [13:0] rows [8] = '{14'h0000, 14'h2001, 14'h3003, 14'h1800, 14'h0C08, 14'h0200, 14'h0380, 14'h3F8B};
  // Rows: edge select, pin level, sync flag expected.
  logic [2:0]  edges [4] = '{3'h3, 3'h0, 3'h6, 3'h5};
  ssirq_regs dut_u (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ev(ev), .rx_sync_capture(rx_sync_capture), .rx_sync_valid(rx_sync_valid), .tx_frame_sync(tx_frame_sync),
    .tx_sync_bits(tx_sync_bits), .transmitter_enabled(transmitter_enabled), .receiver_enabled(receiver_enabled),
    .irq(irq));
  // One word transfer; each phase is held until hready is seen high, so a slow slave is waited for.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Raises event bits for one cycle.
  task automatic pulse(input logic [10:0] p);
    ev <= ev | p;
    @(posedge mclk);
    ev <= ev & ~p;
    @(posedge mclk);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // The sequence needs under 150 cycles; ten thousand means a hang.
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
  initial begin
    rstn = 1'b0;
    {hsel, hwrite, rx_sync_valid, tx_frame_sync, htrans, haddr, hwdata, rx_sync_capture, ev} = '0;
    tick(2);
    rstn <= 1'b1;
    bus(1'b0, `SSIRQ_OFF_IRQ_MASK, 32'h0);
    `SSIRQ_CHECK("mask at reset", 32'h00000000, rd)
    foreach (rows[i]) begin
      ev[10:5] <= rows[i][13:8];
      tick(2);
      bus(1'b0, `SSIRQ_OFF_STATUS, 32'h0);
      `SSIRQ_CHECK("status levels", rows[i][7:0], rd[7:0] & 8'h8B)
    end
    bus(1'b1, `SSIRQ_OFF_TX_SYNC, 32'hFFFFA5C3);
    bus(1'b0, `SSIRQ_OFF_TX_SYNC, 32'h0);
    `SSIRQ_CHECK("tx sync word", 32'h0000A5C3, rd)
    `SSIRQ_CHECK("tx sync bits", 16'hA5C3, tx_sync_bits)
    rx_sync_capture <= 16'h5A3C;
    rx_sync_valid <= 1'b1;
    tick(1);
    rx_sync_valid <= 1'b0;
    bus(1'b0, `SSIRQ_OFF_RX_SYNC, 32'h0);
    `SSIRQ_CHECK("rx sync word", 32'h00005A3C, rd)
    bus(1'b1, `SSIRQ_OFF_IRQ_ENABLE, 32'hFFFFFFFF);
    bus(1'b1, `SSIRQ_OFF_IRQ_DISABLE, 32'h0000000F);
    bus(1'b1, `SSIRQ_OFF_IRQ_ENABLE, 32'h00000000);
    bus(1'b0, `SSIRQ_OFF_IRQ_MASK, 32'h0);
    `SSIRQ_CHECK("mask view", `SSIRQ_IRQ_MASK_BITS & 32'hFFFFFFF0, rd)
    // Counter writes clear the end flags left by the rows before the interrupt is watched.
    ev <= 11'h018;
    tick(1);
    ev <= 11'h000;
    bus(1'b0, `SSIRQ_OFF_STATUS, 32'h0);
    tick(2);
    `SSIRQ_CHECK("irq idle", 1'b0, irq)
    pulse(11'h004);
    tick(2);
    `SSIRQ_CHECK("irq raised", 1'b1, irq)
    bus(1'b1, `SSIRQ_OFF_IRQ_DISABLE, 32'h00000010);
    tick(2);
    `SSIRQ_CHECK("irq masked", 1'b0, irq)
    // A second load over unread data overruns; only a status read clears it.
    pulse(11'h004);
    bus(1'b0, `SSIRQ_OFF_STATUS, 32'h0);
    `SSIRQ_CHECK("overrun set", 2'h3, rd[5:4])
    bus(1'b0, `SSIRQ_OFF_STATUS, 32'h0);
    `SSIRQ_CHECK("overrun cleared", 2'h1, rd[5:4])
    pulse(11'h002);
    bus(1'b0, `SSIRQ_OFF_STATUS, 32'h0);
    `SSIRQ_CHECK("rx emptied", 2'h0, rd[5:4])
    // Counters reach zero, then a counter write clears the end flags while they stay at zero.
    ev <= 11'h140;
    bus(1'b0, `SSIRQ_OFF_STATUS, 32'h0);
    `SSIRQ_CHECK("dma ends set", 32'h00000044, rd & 32'h00000044)
    pulse(11'h018);
    bus(1'b0, `SSIRQ_OFF_STATUS, 32'h0);
    `SSIRQ_CHECK("dma ends cleared", 32'h00000000, rd & 32'h00000044)
    // The pin passes a synchroniser, so six cycles are allowed before the flag is read.
    foreach (edges[i]) begin
      bus(1'b1, `SSIRQ_OFF_CTRL, {29'h0, edges[i][2], 2'h3});
      tx_frame_sync <= edges[i][1];
      tick(6);
      bus(1'b0, `SSIRQ_OFF_STATUS, 32'h0);
      `SSIRQ_CHECK("tx sync flag", edges[i][0], rd[10])
      `SSIRQ_CHECK("enable bits", 2'h3, rd[17:16])
    end
    pulse(11'h001);
    bus(1'b0, `SSIRQ_OFF_STATUS, 32'h0);
    `SSIRQ_CHECK("rx sync flag", 1'b1, rd[11])
    bus(1'b0, `SSIRQ_OFF_STATUS, 32'h0);
    `SSIRQ_CHECK("rx sync cleared", 1'b0, rd[11])
    bus(1'b0, 12'h020, 32'h0);
    `SSIRQ_CHECK("unmapped read", 32'h00000000, rd)
    `SSIRQ_CHECK("enable pins", 2'h3, {receiver_enabled, transmitter_enabled})
    `SSIRQ_CHECK("response okay", 1'b0, hresp)
    // Reset in mid-run while both dma counters sit at zero: no end flag may appear.
    rstn <= 1'b0;
    tick(2);
    rstn <= 1'b1;
    bus(1'b0, `SSIRQ_OFF_IRQ_MASK, 32'h0);
    `SSIRQ_CHECK("mask after reset", 32'h00000000, rd)
    `SSIRQ_CHECK("sync bits after reset", 16'h0000, tx_sync_bits)
    bus(1'b0, `SSIRQ_OFF_STATUS, 32'h0);
    `SSIRQ_CHECK("dma ends after reset", 32'h00000000, rd & 32'h00030044)
    `SSIRQ_CHECK("irq after reset", 1'b0, irq)
    give_verdict();
  end
endmodule
`default_nettype wire
